// ---- verilog/backlight_pkg.sv ----
`default_nettype none
package backlight_pkg;

	// ****************************************************************
	// Timebase
	// ****************************************************************
	localparam int CLK_HZ          = 125_000_000;
	localparam int PWM_RATE_HZ     = 256;
	localparam int PWM_SLOTS       = 32;
	localparam int RAMP_RATE_HZ    = 64;
	// Rounded down so the frame rate never falls below 256 Hz
	localparam int SLOT_CYCLES     = CLK_HZ / (PWM_RATE_HZ * PWM_SLOTS);
	localparam int FRAMES_PER_RAMP = PWM_RATE_HZ / RAMP_RATE_HZ;

	// ****************************************************************
	// Channels and duty codes
	// ****************************************************************
	localparam int         NUM_CH    = 3;
	localparam int         CH_MAIN   = 0;
	localparam int         CH_AUX    = 1;
	localparam int         CH_KEYPAD = 2;
	localparam logic [5:0] DUTY_OFF  = 6'h00;
	localparam logic [5:0] DUTY_FULL = 6'h20;

	// ****************************************************************
	// Register map
	// ****************************************************************
	localparam logic [7:0] ADDR_MAIN_CFG   = 8'h00;
	localparam logic [7:0] ADDR_AUX_CFG    = 8'h04;
	localparam logic [7:0] ADDR_KEYPAD_CFG = 8'h08;
	localparam logic [7:0] ADDR_STATUS     = 8'h0c;
	localparam int         STAT_EN_BIT     = 6;
	localparam int         STAT_ON_BIT     = 7;
	localparam int         STAT_SHARE_BIT  = 24;
	localparam int         STAT_LOCK_BIT   = 25;
	localparam logic [1:0] RESP_OKAY       = 2'h0;
	localparam logic [1:0] RESP_SLVERR     = 2'h2;

	// Per channel settings; word bits [2:0] level, [3] high range,
	// [4] ramp, [13:8] duty
	typedef struct packed {
		logic [5:0] dutyCode;
		logic       rampEnable;
		logic       highRangeSelect;
		logic [2:0] currentLevelCode;
	} chanCfg_t;

	localparam chanCfg_t CFG_RESET = '0;

endpackage
`default_nettype wire

// ---- verilog/backlight_timebase.sv ----
`timescale 1ns/10ps
`default_nettype none
module backlight_timebase
	import backlight_pkg::*;
#(
	parameter int HalfCycles = SLOT_CYCLES / 2
) (
	// Clock and reset
	input  wire logic       core_clk,
	input  wire logic       reset_n,
	// Frame position
	output logic [4:0]      slot,
	output logic            secondHalf,
	output logic            rampTick
);

	localparam int CW = (HalfCycles > 1) ? $clog2(HalfCycles) : 1;
	localparam int FW = $clog2(FRAMES_PER_RAMP);

	if (HalfCycles < 2) begin : gChk
		$error("HalfCycles must be at least 2");
	end

	typedef struct packed {
		logic [CW-1:0] cnt;
		logic          half;
		logic [4:0]    slot;
		logic [FW-1:0] frame;
		logic          rampTick;
	} tb_t;

	tb_t s_q;
	tb_t s_d;

	// Half slot divider, 32 slot frame, ramp tick every fourth frame
	always_comb begin
		s_d = s_q;
		s_d.rampTick = 1'b0;
		if (s_q.cnt == CW'(HalfCycles - 1)) begin // [R12]
			s_d.cnt = '0;
			s_d.half = ~s_q.half;
			if (s_q.half) begin
				s_d.slot = s_q.slot + 5'h01;
				if (s_q.slot == 5'h1f) begin
					s_d.frame = s_q.frame + FW'(1);
					if (s_q.frame == FW'(FRAMES_PER_RAMP - 1)) begin
						s_d.rampTick = 1'b1; // [R05]
					end
				end
			end
		end else begin
			s_d.cnt = s_q.cnt + CW'(1);
		end
	end

	// State register
	always_ff @(posedge core_clk) begin
		if (!reset_n) begin
			s_q <= '0;
		end else begin
			s_q <= s_d;
		end
	end

	assign slot       = s_q.slot;
	assign secondHalf = s_q.half;
	assign rampTick   = s_q.rampTick;

endmodule // backlight_timebase
`default_nettype wire

// ---- verilog/backlight_channel.sv ----
`timescale 1ns/10ps
`default_nettype none
module backlight_channel
	import backlight_pkg::*;
(
	// Clock and reset
	input  wire logic       core_clk,
	input  wire logic       reset_n,
	// Timebase
	input  wire logic [4:0] slot,
	input  wire logic       secondHalf,
	input  wire logic       rampTick,
	// Settings
	input  wire logic [5:0] dutyCode,
	input  wire logic       rampEnable,
	// Result
	output logic [5:0]      appliedDuty,
	output logic            pwmOn
);

	typedef struct packed {
		logic [5:0] applied;
		logic       on;
	} ch_t;

	ch_t        s_q;
	ch_t        s_d;
	logic [5:0] target;
	logic [5:0] pos;

	// Ramp toward target, then compare frame position with applied duty
	always_comb begin
		s_d = s_q;
		target = dutyCode[5] ? DUTY_FULL : dutyCode; // [R03]
		pos = {1'b0, slot};
		if (!rampEnable) begin
			s_d.applied = target; // [R06]
		end else if (rampTick) begin
			if (s_q.applied < target) begin
				s_d.applied = s_q.applied + 6'h01; // [R05]
			end else if (s_q.applied > target) begin
				s_d.applied = s_q.applied - 6'h01; // [R05]
			end
		end
		if (s_q.applied == DUTY_OFF) begin
			s_d.on = 1'b0; // [R03]
		end else if (s_q.applied >= DUTY_FULL) begin
			s_d.on = 1'b1; // [R03]
		end else begin
			// Extra half slot covers the string switcher start-up
			s_d.on = (pos < s_q.applied) // [R04]
				|| (pos == s_q.applied && !secondHalf); // [R11]
		end
	end

	// State register
	always_ff @(posedge core_clk) begin
		if (!reset_n) begin
			s_q <= '0;
		end else begin
			s_q <= s_d;
		end
	end

	assign appliedDuty = s_q.applied;
	assign pwmOn       = s_q.on;

endmodule // backlight_channel
`default_nettype wire

// ---- verilog/backlight_pwm_ramp_sharing.sv ----
// Function
// [R01] Three channels, each with level and duty
// [R02] Sink current is code times 3 or 6 mA
// [R03] Duty 0 off, 1..31 of 32, top bit full
// [R04] Below full duty, 256 Hz switching frame
// [R05] Ramp steps duty by 1/32 each 1/64 s
// [R06] Ramp off: new duty applies immediately
// [R07] Channel enabled when duty setting nonzero
// [R08] At most two driven; all three drives none
// [R09] Two enabled channels alternate half the time
// [R10] Sharing doubles each active channel's current
// [R11] On period lengthened for switcher start-up
// [R12] Ticks from own clock; reset clears, outputs off
//
// The register addresses and the AXI4-Lite register port were chosen for this implementation.
`timescale 1ns/10ps
`default_nettype none
module backlight_pwm_ramp_sharing
	import backlight_pkg::*;
#(
	parameter int AddrWidth = 8,
	parameter int SlotCycles = SLOT_CYCLES
) (
	// Clock and reset
	input  wire logic                 core_clk,
	input  wire logic                 reset_n,
	// AXI4-Lite write address
	input  wire logic [AddrWidth-1:0] awaddr,
	input  wire logic                 awvalid,
	output logic                      awready,
	// AXI4-Lite write data
	input  wire logic [31:0]          wdata,
	input  wire logic [3:0]           wstrb,
	input  wire logic                 wvalid,
	output logic                      wready,
	// AXI4-Lite write response
	output logic [1:0]                bresp,
	output logic                      bvalid,
	input  wire logic                 bready,
	// AXI4-Lite read address
	input  wire logic [AddrWidth-1:0] araddr,
	input  wire logic                 arvalid,
	output logic                      arready,
	// AXI4-Lite read data
	output logic [31:0]               rdata,
	output logic [1:0]                rresp,
	output logic                      rvalid,
	input  wire logic                 rready,
	// Current sinks, current in units of 3 mA
	output logic [2:0]                sinkOn,
	output logic [4:0]                mainCurrent,
	output logic [4:0]                auxCurrent,
	output logic [4:0]                keypadCurrent
);

	// ****************************************************************
	// Elaboration checks
	// ****************************************************************
	if (AddrWidth < 4 || AddrWidth > 32) begin : gChkAddr
		$error("AddrWidth must be 4 to 32");
	end
	if (SlotCycles < 4) begin : gChkSlot
		$error("SlotCycles must be at least 4");
	end

	// ****************************************************************
	// State
	// ****************************************************************
	localparam logic [2:0] IDX_STATUS   = 3'd3;
	localparam logic [2:0] IDX_UNMAPPED = 3'd4;

	typedef struct packed {
		logic                 awReady;
		logic                 awHeld;
		logic [AddrWidth-1:0] awAddr;
		logic                 wReady;
		logic                 wHeld;
		logic [31:0]          wData;
		logic [3:0]           wStrb;
		logic                 bValid;
		logic [1:0]           bResp;
		logic                 arReady;
		logic                 rValid;
		logic [31:0]          rData;
		logic [1:0]           rResp;
		chanCfg_t [2:0]       cfg;
		logic [2:0]           sinkOn;
		logic [2:0][4:0]      current;
	} top_t;

	top_t       s_q;
	top_t       s_d;

	// Timebase and channel results
	logic [4:0] slot;
	logic       secondHalf;
	logic       rampTick;
	logic [5:0] appliedDuty [NUM_CH];
	logic       pwmOn [NUM_CH];

	// Arbitration terms
	logic [2:0] enabledSet;
	logic [1:0] enabledCount;
	logic       sharing;
	logic       lockout;
	logic [2:0] firstEnabled;
	logic [2:0] ownsPhase;
	logic [2:0] wrIdx;
	logic [2:0] rdIdx;

	// ****************************************************************
	// Helper functions
	// ****************************************************************

	// Register index of a byte address; low two bits ignored
	function automatic logic [2:0] regIndex(
		input logic [AddrWidth-1:0] addr
	);
		logic [31:0] a;
		// Widen first so any address width decodes the same map
		a = 32'(addr) & 32'hffff_fffc;
		case (a)
			32'(ADDR_MAIN_CFG):   regIndex = 3'(CH_MAIN);
			32'(ADDR_AUX_CFG):    regIndex = 3'(CH_AUX);
			32'(ADDR_KEYPAD_CFG): regIndex = 3'(CH_KEYPAD);
			32'(ADDR_STATUS):     regIndex = IDX_STATUS;
			default:              regIndex = IDX_UNMAPPED;
		endcase
	endfunction

	// Settings word as software sees it
	function automatic logic [31:0] cfgWord(input chanCfg_t c);
		cfgWord = {18'h00000, c.dutyCode, 3'h0, c.rampEnable,
			c.highRangeSelect, c.currentLevelCode};
	endfunction

	// Byte-lane merge of a write into a settings register
	function automatic chanCfg_t cfgMerge(
		input chanCfg_t    c,
		input logic [31:0] d,
		input logic [3:0]  strb
	);
		cfgMerge = c;
		if (strb[0]) begin
			cfgMerge.currentLevelCode = d[2:0];
			cfgMerge.highRangeSelect  = d[3];
			cfgMerge.rampEnable       = d[4];
		end
		if (strb[1]) begin
			cfgMerge.dutyCode = d[13:8];
		end
	endfunction

	// Sink current in 3 mA units: code, doubled per range and sharing
	function automatic logic [4:0] currentUnits(
		input logic [2:0] level,
		input logic       hi,
		input logic       dbl
	);
		logic [4:0] base;
		base = {2'b00, level}; // [R02]
		currentUnits = base << ({1'b0, hi} + {1'b0, dbl}); // [R02] [R10]
	endfunction

	// ****************************************************************
	// Timebase and channels
	// ****************************************************************
	backlight_timebase #(
		.HalfCycles (SlotCycles / 2)
	) uTimebase (
		.core_clk   (core_clk),
		.reset_n    (reset_n),
		.slot       (slot),
		.secondHalf (secondHalf),
		.rampTick   (rampTick)
	);

	for (genvar i = 0; i < NUM_CH; i++) begin : gCh
		backlight_channel uChannel (
			.core_clk    (core_clk),
			.reset_n     (reset_n),
			.slot        (slot),
			.secondHalf  (secondHalf),
			.rampTick    (rampTick),
			.dutyCode    (s_q.cfg[i].dutyCode), // [R01]
			.rampEnable  (s_q.cfg[i].rampEnable),
			.appliedDuty (appliedDuty[i]),
			.pwmOn       (pwmOn[i])
		);
	end

	// ****************************************************************
	// Arbitration
	// ****************************************************************

	// Enable follows the written setting, not the ramped duty
	always_comb begin
		for (int i = 0; i < NUM_CH; i++) begin
			enabledSet[i] = (s_q.cfg[i].dutyCode != DUTY_OFF); // [R07]
		end
		enabledCount = 2'({1'b0, enabledSet[0]}
			+ {1'b0, enabledSet[1]} + {1'b0, enabledSet[2]});
		lockout = (enabledCount == 2'd3); // [R08]
		sharing = (enabledCount == 2'd2); // [R09]
		firstEnabled = enabledSet & ~(enabledSet - 3'b001);
		// Lower enabled channel owns first halves, the other second
		for (int i = 0; i < NUM_CH; i++) begin
			ownsPhase[i] = !sharing
				|| (firstEnabled[i] ? !secondHalf : secondHalf); // [R09]
		end
	end

	// ****************************************************************
	// Bus slave and output logic
	// ****************************************************************
	always_comb begin
		s_d = s_q;
		wrIdx = regIndex(s_q.awAddr);
		rdIdx = regIndex(araddr);

		// Write address and data, taken in either order
		if (awvalid && s_q.awReady) begin
			s_d.awAddr  = awaddr;
			s_d.awHeld  = 1'b1;
			s_d.awReady = 1'b0;
		end
		if (wvalid && s_q.wReady) begin
			s_d.wData  = wdata;
			s_d.wStrb  = wstrb;
			s_d.wHeld  = 1'b1;
			s_d.wReady = 1'b0;
		end

		// Both halves held: update the register and answer
		if (s_q.awHeld && s_q.wHeld && !s_q.bValid) begin
			s_d.awHeld = 1'b0;
			s_d.wHeld  = 1'b0;
			s_d.bValid = 1'b1;
			s_d.bResp  = RESP_OKAY;
			if (wrIdx < 3'(NUM_CH)) begin
				s_d.cfg[wrIdx] = cfgMerge(s_q.cfg[wrIdx],
					s_q.wData, s_q.wStrb);
			end else if (wrIdx == IDX_UNMAPPED) begin
				s_d.bResp = RESP_SLVERR;
			end
		end
		if (s_q.bValid && bready) begin
			s_d.bValid  = 1'b0;
			s_d.awReady = 1'b1;
			s_d.wReady  = 1'b1;
		end

		// Read: data sampled at the edge the address is taken
		if (arvalid && s_q.arReady) begin
			s_d.arReady = 1'b0;
			s_d.rValid  = 1'b1;
			s_d.rResp   = RESP_OKAY;
			s_d.rData   = 32'h00000000;
			if (rdIdx < 3'(NUM_CH)) begin
				s_d.rData = cfgWord(s_q.cfg[rdIdx]);
			end else if (rdIdx == IDX_STATUS) begin
				for (int i = 0; i < NUM_CH; i++) begin
					s_d.rData[i*8 +: 6]          = appliedDuty[i];
					s_d.rData[i*8 + STAT_EN_BIT] = enabledSet[i];
					s_d.rData[i*8 + STAT_ON_BIT] = s_q.sinkOn[i];
				end
				s_d.rData[STAT_SHARE_BIT] = sharing;
				s_d.rData[STAT_LOCK_BIT]  = lockout;
			end else begin
				s_d.rResp = RESP_SLVERR;
			end
		end
		if (s_q.rValid && rready) begin
			s_d.rValid  = 1'b0;
			s_d.arReady = 1'b1;
		end

		// Sink gates and currents; all off under lockout
		for (int i = 0; i < NUM_CH; i++) begin
			s_d.sinkOn[i] = enabledSet[i] && !lockout // [R08]
				&& pwmOn[i] && ownsPhase[i]; // [R09]
			s_d.current[i] = s_d.sinkOn[i]
				? currentUnits(s_q.cfg[i].currentLevelCode,
					s_q.cfg[i].highRangeSelect, sharing) // [R10]
				: 5'h00;
		end
	end

	// State register; sinks off and bus idle after reset
	always_ff @(posedge core_clk) begin
		if (!reset_n) begin
			s_q         <= '0; // [R12]
			s_q.awReady <= 1'b1;
			s_q.wReady  <= 1'b1;
			s_q.arReady <= 1'b1;
		end else begin
			s_q <= s_d;
		end
	end

	// ****************************************************************
	// Outputs
	// ****************************************************************
	assign awready       = s_q.awReady;
	assign wready        = s_q.wReady;
	assign bvalid        = s_q.bValid;
	assign bresp         = s_q.bResp;
	assign arready       = s_q.arReady;
	assign rvalid        = s_q.rValid;
	assign rdata         = s_q.rData;
	assign rresp         = s_q.rResp;
	assign sinkOn        = s_q.sinkOn;
	assign mainCurrent   = s_q.current[CH_MAIN];
	assign auxCurrent    = s_q.current[CH_AUX];
	assign keypadCurrent = s_q.current[CH_KEYPAD];

endmodule // backlight_pwm_ramp_sharing
`default_nettype wire

// ---- bench/backlight_monitor.sv ----
`timescale 1ns/10ps
`default_nettype none
// ****************************************************************
// Bus handshake and sink output checks
// ****************************************************************
module backlight_monitor
	import backlight_pkg::*;
(
	// Clock and reset
	input  wire logic        core_clk,
	input  wire logic        reset_n,
	// Register bus
	input  wire logic        awvalid,
	input  wire logic        awready,
	input  wire logic        wvalid,
	input  wire logic        wready,
	input  wire logic [1:0]  bresp,
	input  wire logic        bvalid,
	input  wire logic        bready,
	input  wire logic        arvalid,
	input  wire logic        arready,
	input  wire logic [31:0] rdata,
	input  wire logic        rvalid,
	input  wire logic        rready,
	// Current sinks
	input  wire logic [2:0]  sinkOn,
	input  wire logic [4:0]  mainCurrent,
	input  wire logic [4:0]  auxCurrent,
	input  wire logic [4:0]  keypadCurrent
);
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!reset_n);

	// Idle sinks carry no current
	a_main_idle_zero: assert property (
		!sinkOn[0] |-> mainCurrent == 5'h00)
		else $error("main current while idle");
	a_aux_idle_zero: assert property (
		!sinkOn[1] |-> auxCurrent == 5'h00)
		else $error("aux current while idle");
	a_keypad_idle_zero: assert property (
		!sinkOn[2] |-> keypadCurrent == 5'h00)
		else $error("keypad current while idle");
	// Reset leaves every sink dark
	a_reset_dark: assert property (disable iff (1'b0)
		!reset_n |=> sinkOn == 3'h0)
		else $error("sink on after reset");
	// Shared boost serves one string at a time
	a_one_sink_on: assert property ($onehot0(sinkOn))
		else $error("two sinks on together");
	// Bus answers and held responses; write answers two cycles after take
	a_write_answer: assert property (
		awvalid && awready && wvalid && wready |-> ##2 bvalid)
		else $error("write not answered");
	a_resp_stands: assert property (bvalid && !bready
		|=> bvalid && $stable(bresp))
		else $error("write response dropped");
	a_ready_gate: assert property (bvalid |-> !awready && !wready)
		else $error("ready while response pending");
	a_read_answer: assert property (arvalid && arready
		|=> rvalid && !arready)
		else $error("read not answered");
	a_rdata_stands: assert property (rvalid && !rready
		|=> rvalid && $stable(rdata))
		else $error("read data dropped");

	// Main scenarios reached
	c_slverr: cover property (bvalid && bresp == RESP_SLVERR);
	c_shared: cover property (sinkOn[0] && mainCurrent == 5'h04);
	c_keypad: cover property (sinkOn[2]);
endmodule // backlight_monitor

bind backlight_pwm_ramp_sharing backlight_monitor mon (
	.core_clk(core_clk), .reset_n(reset_n), .awvalid(awvalid),
	.awready(awready), .wvalid(wvalid), .wready(wready),
	.bresp(bresp), .bvalid(bvalid), .bready(bready),
	.arvalid(arvalid), .arready(arready), .rdata(rdata),
	.rvalid(rvalid), .rready(rready), .sinkOn(sinkOn),
	.mainCurrent(mainCurrent), .auxCurrent(auxCurrent),
	.keypadCurrent(keypadCurrent)
);
`default_nettype wire

// ---- bench/led_string_model.sv ----
`timescale 1ns/10ps
`default_nettype none
// ****************************************************************
// LED strings on a shared boost: conduction time and current
// ****************************************************************
module led_string_model
	import backlight_pkg::*;
(
	// Clock
	input  wire logic       core_clk,
	// Sinks
	input  wire logic [2:0] sinkOn,
	input  wire logic [4:0] mainCurrent,
	input  wire logic [4:0] auxCurrent,
	input  wire logic [4:0] keypadCurrent,
	// Observations
	output int              onCount [NUM_CH],
	output logic [4:0]      amps [NUM_CH],
	output int              overlap
);
	// Count conducting cycles and keep the current seen while on
	always @(posedge core_clk) begin
		for (int i = 0; i < NUM_CH; i++) begin
			if (sinkOn[i]) onCount[i] <= onCount[i] + 1;
		end
		if (sinkOn[0]) amps[0] <= mainCurrent;
		if (sinkOn[1]) amps[1] <= auxCurrent;
		if (sinkOn[2]) amps[2] <= keypadCurrent;
		// Boost can feed one string at a time
		if ($countones(sinkOn) > 1) overlap <= overlap + 1;
	end
endmodule // led_string_model
`default_nettype wire

// ---- bench/backlight_pwm_ramp_sharing_bench.sv ----
`timescale 1ns/10ps
`default_nettype none
// ****************************************************************
// Register driven scenarios for the backlight block
// ****************************************************************
module backlight_pwm_ramp_sharing_bench
	import backlight_pkg::*;
;
	logic        core_clk = 1'b0;
	logic        reset_n, awvalid, wvalid, bready, arvalid, rready;
	logic [7:0]  awaddr, araddr;
	logic [31:0] wdata, rdata, rd;
	logic [3:0]  wstrb;
	logic        awready, wready, bvalid, arready, rvalid;
	logic [1:0]  bresp, rresp, resp;
	logic [2:0]  sinkOn;
	logic [4:0]  mainCurrent, auxCurrent, keypadCurrent;
	logic [4:0]  amps [NUM_CH];
	int          onCount [NUM_CH];
	int          overlap;
	int          fails = 0;
	int          checked = 0;
	int          cycles = 0;

	always #4 core_clk = ~core_clk;

	backlight_pwm_ramp_sharing #(.SlotCycles(8)) dut (
		.core_clk(core_clk), .reset_n(reset_n), .awaddr(awaddr),
		.awvalid(awvalid), .awready(awready), .wdata(wdata),
		.wstrb(wstrb), .wvalid(wvalid), .wready(wready),
		.bresp(bresp), .bvalid(bvalid), .bready(bready),
		.araddr(araddr), .arvalid(arvalid), .arready(arready),
		.rdata(rdata), .rresp(rresp), .rvalid(rvalid),
		.rready(rready), .sinkOn(sinkOn), .mainCurrent(mainCurrent),
		.auxCurrent(auxCurrent), .keypadCurrent(keypadCurrent));
	led_string_model leds (.core_clk(core_clk), .sinkOn(sinkOn),
		.mainCurrent(mainCurrent), .auxCurrent(auxCurrent),
		.keypadCurrent(keypadCurrent), .onCount(onCount),
		.amps(amps), .overlap(overlap));

	// Compare and verdict
	task automatic check(input string what, input logic [31:0] exp,
		input logic [31:0] got);
		checked++;
		if (got !== exp) begin
			fails++;
			$display("mismatch %s expected %h seen %h", what, exp, got);
		end
	endtask

	task complete_run;
		$display("checked %0d fails %0d", checked, fails);
		if (fails == 0 && checked > 0) $display("*** PASS ***");
		else $display("*** FAIL ***");
		$finish;
	endtask

	// Bus master cycles; local flags track what is still pending
	task automatic axiWrite(input logic [7:0] a, input logic [31:0] d,
		output logic [1:0] r);
		logic aw, w, b;
		aw = 1'b1;
		w = 1'b1;
		b = 1'b1;
		@(posedge core_clk);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		while (aw || w || b) begin
			@(posedge core_clk);
			if (aw && awready) begin
				aw = 1'b0;
				awvalid <= 1'b0;
			end
			if (w && wready) begin
				w = 1'b0;
				wvalid <= 1'b0;
			end
			if (b && bvalid) begin
				b = 1'b0;
				r = bresp;
				bready <= 1'b0;
			end
		end
	endtask

	task automatic axiRead(input logic [7:0] a, output logic [31:0] d,
		output logic [1:0] r);
		logic ar, rr;
		ar = 1'b1;
		rr = 1'b1;
		@(posedge core_clk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		while (ar || rr) begin
			@(posedge core_clk);
			if (ar && arready) begin
				ar = 1'b0;
				arvalid <= 1'b0;
			end
			if (rr && rvalid) begin
				rr = 1'b0;
				d = rdata;
				r = rresp;
				rready <= 1'b0;
			end
		end
	endtask

	function automatic logic [31:0] cfgWord(input logic [2:0] lvl,
		input logic hi, input logic ramp, input logic [5:0] duty);
		return {18'h0, duty, 3'h0, ramp, hi, lvl};
	endfunction

	// Settings write that must be answered okay
	task automatic setCfg(input logic [7:0] a, input logic [2:0] lvl,
		input logic hi, input logic ramp, input logic [5:0] duty);
		logic [1:0] r;
		axiWrite(a, cfgWord(lvl, hi, ramp, duty), r);
		check("bresp", {30'h0, RESP_OKAY}, {30'h0, r});
	endtask

	// Conduction over one 256 cycle frame
	task automatic measure(input int ch, input int expOn,
		input logic [4:0] expAmps);
		int c0;
		repeat (8) @(posedge core_clk);
		c0 = onCount[ch];
		repeat (256) @(posedge core_clk);
		check("on cycles", expOn, onCount[ch] - c0);
		if (expOn > 0) check("current", {27'h0, expAmps}, {27'h0, amps[ch]});
	endtask

	// Hang guard
	always @(posedge core_clk) begin
		cycles <= cycles + 1;
		if (cycles == 20000) begin
			fails++;
			$display("mismatch cycles expected below 20000 seen %0d", cycles);
			complete_run;
		end
	end

	initial begin
		{reset_n, awvalid, wvalid, bready, arvalid, rready} = 6'h00;
		{awaddr, araddr, wdata} = 48'h0;
		wstrb = 4'hf;
		repeat (8) @(posedge core_clk);
		reset_n <= 1'b1;
		axiRead(ADDR_MAIN_CFG, rd, resp);
		check("main cfg", 32'h0, rd);
		axiRead(ADDR_STATUS, rd, resp);
		check("status", 32'h0, rd);
		$display("test reset done");
		setCfg(ADDR_MAIN_CFG, 3'h5, 1'b1, 1'b0, 6'h10);
		axiRead(ADDR_STATUS, rd, resp);
		check("applied", 32'h10, rd & 32'h3f);
		axiRead(ADDR_MAIN_CFG, rd, resp);
		check("main cfg", cfgWord(3'h5, 1'b1, 1'b0, 6'h10), rd);
		measure(CH_MAIN, 132, 5'h0a);
		setCfg(ADDR_MAIN_CFG, 3'h5, 1'b0, 1'b0, 6'h3f);
		measure(CH_MAIN, 256, 5'h05);
		measure(CH_KEYPAD, 0, 5'h00);
		$display("test single done");
		setCfg(ADDR_MAIN_CFG, 3'h2, 1'b0, 1'b0, 6'h20);
		setCfg(ADDR_KEYPAD_CFG, 3'h3, 1'b1, 1'b0, 6'h20);
		measure(CH_MAIN, 128, 5'h04);
		measure(CH_KEYPAD, 128, 5'h0c);
		axiRead(ADDR_STATUS, rd, resp);
		check("sharing", 32'h0100_0000, rd & 32'h0300_0000);
		$display("test sharing done");
		setCfg(ADDR_AUX_CFG, 3'h1, 1'b0, 1'b0, 6'h01);
		measure(CH_MAIN, 0, 5'h00);
		measure(CH_AUX, 0, 5'h00);
		measure(CH_KEYPAD, 0, 5'h00);
		axiRead(ADDR_STATUS, rd, resp);
		check("lockout", 32'h0200_0000, rd & 32'h0300_0000);
		$display("test lockout done");
		setCfg(ADDR_KEYPAD_CFG, 3'h0, 1'b0, 1'b0, 6'h00);
		setCfg(ADDR_AUX_CFG, 3'h1, 1'b0, 1'b0, 6'h20);
		measure(CH_AUX, 128, 5'h02);
		check("overlap", 32'h0, overlap);
		setCfg(ADDR_AUX_CFG, 3'h0, 1'b0, 1'b0, 6'h00);
		setCfg(ADDR_MAIN_CFG, 3'h1, 1'b0, 1'b0, 6'h00);
		setCfg(ADDR_MAIN_CFG, 3'h1, 1'b0, 1'b1, 6'h04);
		axiRead(ADDR_STATUS, rd, resp);
		check("ramp start", 32'h1, {31'h0, rd[5:0] < 6'h02});
		repeat (5120) @(posedge core_clk);
		axiRead(ADDR_STATUS, rd, resp);
		check("ramp end", 32'h4, rd & 32'h3f);
		measure(CH_MAIN, 36, 5'h01);
		setCfg(ADDR_MAIN_CFG, 3'h1, 1'b0, 1'b1, 6'h02);
		axiRead(ADDR_STATUS, rd, resp);
		check("ramp down start", 32'h1, {31'h0, rd[5:0] > 6'h02});
		repeat (3072) @(posedge core_clk);
		axiRead(ADDR_STATUS, rd, resp);
		check("ramp down end", 32'h2, rd & 32'h3f);
		$display("test ramp done");
		// Low lane only: level, range and ramp change, duty stays
		wstrb <= 4'h1;
		axiWrite(ADDR_MAIN_CFG, 32'h0000_3f0f, resp);
		wstrb <= 4'hf;
		axiRead(ADDR_MAIN_CFG, rd, resp);
		check("lane merge", cfgWord(3'h7, 1'b1, 1'b0, 6'h02), rd);
		axiWrite(8'h10, 32'hffff_ffff, resp);
		check("bresp", {30'h0, RESP_SLVERR}, {30'h0, resp});
		axiRead(8'h10, rd, resp);
		check("rresp", {30'h0, RESP_SLVERR}, {30'h0, resp});
		check("rdata", 32'h0, rd);
		axiWrite(ADDR_STATUS, 32'hffff_ffff, resp);
		check("bresp", {30'h0, RESP_OKAY}, {30'h0, resp});
		$display("test errors done");
		complete_run;
	end
endmodule // backlight_pwm_ramp_sharing_bench
`default_nettype wire
